// File: mic_irq_map.vh
`ifndef MIC_IRQ_MAP_VH
`define MIC_IRQ_MAP_VH

// register indices; byte address is four times the index
`define MIC_IDX_PRI0 3'h0
`define MIC_IDX_PRI1 3'h1
`define MIC_IDX_PRI2 3'h2
`define MIC_IDX_PRI3 3'h3
`define MIC_IDX_MF0 3'h4
`define MIC_IDX_MF1 3'h5
`define MIC_IDX_MF2 3'h6
`define MIC_IDX_MF3 3'h7
`define MIC_NUM_REG 8
`define MIC_APB_AW 8

// reset value and implemented bits
`define MIC_RST_VAL 8'h00
`define MIC_MASK_PRI0 8'h7F
`define MIC_MASK_PRI 8'hFF
`define MIC_MASK_MF 8'h33

// field positions
`define MIC_BIT_GLOBAL 0
`define MIC_EN_SHIFT 4
`define MIC_EN_SHIFT_PRI0 3
`define MIC_BIT_MF_SRCB_F 5
`define MIC_BIT_MF_SRCA_F 4
`define MIC_BIT_MF_SRCB_E 1
`define MIC_BIT_MF_SRCA_E 0

// vector table, entry 13 first: register, flag bit, {group valid, group}
`define MIC_NUM_VEC 14
`define MIC_NUM_DIRECT 10
`define MIC_VEC_REG {3'h3,3'h3,3'h3,3'h3,3'h2,3'h2,3'h2,3'h2,3'h1,3'h1,3'h1,3'h0,3'h0,3'h0}
`define MIC_VEC_BIT {3'h4,3'h5,3'h6,3'h7,3'h4,3'h5,3'h6,3'h7,3'h5,3'h6,3'h7,3'h4,3'h5,3'h6}
`define MIC_VEC_GRP {3'h7,3'h4,3'h5,3'h0,3'h0,3'h6,3'h0,3'h0,3'h0,3'h0,3'h0,3'h0,3'h0,3'h0}

// priority list, highest first in the low nibble
`define MIC_PRIO_DEF 56'hDCBA9876543210
`define MIC_VEC_BASE 12'h004
`define MIC_VEC_STEP 12'h004
`define MIC_DEPTH_W 4

`endif

// File: mic_prio_pick.v
`timescale 1ns/1ps
`default_nettype none
`include "mic_irq_map.vh"

module mic_prio_pick #(
  parameter integer N = `MIC_NUM_VEC,
  parameter integer IW = 4,
  parameter [N*IW-1:0] PRIO = `MIC_PRIO_DEF
) (
  input wire [N-1:0] pend,
  output reg found,
  output reg [IW-1:0] idx
);
  integer i;
  reg [IW-1:0] k;

  // walk from lowest priority up so the highest pending one wins
  always @* begin
    found = 1'b0;
    idx = {IW{1'b0}};
    k = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      k = PRIO[i*IW +: IW];
      if (pend[k]) begin
        found = 1'b1;
        idx = k;
      end
    end
  end
endmodule

`default_nettype wire

// File: mic_irq_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "mic_irq_map.vh"

module mic_irq_ctrl #(
  parameter integer AW = `MIC_APB_AW,
  parameter [55:0] PRIO = `MIC_PRIO_DEF,
  parameter [11:0] VEC_BASE = `MIC_VEC_BASE,
  parameter [11:0] VEC_STEP = `MIC_VEC_STEP
) (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  input wire [9:0] directEvent,
  input wire [7:0] groupEvent,
  input wire stackFull,
  input wire irqAck,
  input wire retiPulse,
  output reg irqReq_r,
  output reg [3:0] irqVector_r,
  output reg [11:0] vectorAddr_r,
  output reg pushStrobe_r,
  output reg popStrobe_r,
  output reg inService_r,
  output reg wake_r
);
  localparam integer NV = `MIC_NUM_VEC;
  localparam integer NR = `MIC_NUM_REG;
  localparam [3*NV-1:0] VREG = `MIC_VEC_REG;
  localparam [3*NV-1:0] VBIT = `MIC_VEC_BIT;
  localparam [3*NV-1:0] VGRP = `MIC_VEC_GRP;

  function integer vecReg;
    input integer i;
    begin
      vecReg = VREG[i*3 +: 3];
    end
  endfunction

  function integer vecBit;
    input integer i;
    begin
      vecBit = VBIT[i*3 +: 3];
    end
  endfunction

  function integer vecGrp;
    input integer i;
    begin
      vecGrp = VGRP[i*3 +: 3];
    end
  endfunction

  // enable position of a flag; the first register packs its enables one bit higher
  function integer vecEn;
    input integer i;
    begin
      if (vecReg(i) == `MIC_IDX_PRI0) begin
        vecEn = vecBit(i) - `MIC_EN_SHIFT_PRI0;
      end else begin
        vecEn = vecBit(i) - `MIC_EN_SHIFT;
      end
    end
  endfunction

  // maps a vector number onto its direct event input
  function integer dirMap;
    input integer i;
    begin
      if (i < 8) begin
        dirMap = i;
      end else begin
        dirMap = i - 1;
      end
    end
  endfunction

  function [7:0] implMask;
    input integer r;
    begin
      case (r)
        0: implMask = `MIC_MASK_PRI0;
        1: implMask = `MIC_MASK_PRI;
        2: implMask = `MIC_MASK_PRI;
        3: implMask = `MIC_MASK_PRI;
        default: implMask = `MIC_MASK_MF;
      endcase
    end
  endfunction

  reg [7:0] regFile_r [0:NR-1];
  reg [8*NR-1:0] regNxt;
  reg [8*NR-1:0] setAll;
  reg [8*NR-1:0] clrAll;
  reg [`MIC_DEPTH_W-1:0] depth_r;
  reg [`MIC_DEPTH_W-1:0] depthNxt;
  reg [7:0] tmpByte;
  integer r;
  integer v;
  integer g;
  integer ri;
  integer bi;

  wire [NV-1:0] vecSet;
  wire [NV-1:0] pend;
  wire [NV-1:0] ackHot;
  wire [3:0] grpHit;
  wire pickFound;
  wire [3:0] pickIdx;
  wire globalEn;
  wire apbAcc;
  wire apbDone;
  wire mapped;
  wire [2:0] regIdx;
  wire wrEn;
  wire ackOk;
  wire [23:0] vecProd;
  wire [11:0] vecAddr;
  wire popOk;
  wire pushOk;
  localparam [`MIC_DEPTH_W-1:0] DEPTH_MAX = {`MIC_DEPTH_W{1'b1}};

  assign globalEn = regFile_r[`MIC_IDX_PRI0][`MIC_BIT_GLOBAL];

  // apb decode: one word per register, anything else errors
  assign apbAcc = psel & penable;
  assign apbDone = apbAcc & pready_r;
  assign regIdx = paddr[4:2];
  assign mapped = (paddr[AW-1:5] == {(AW-5){1'b0}}) && (paddr[1:0] == 2'h0);
  assign wrEn = apbDone & pwrite & mapped;

  // group hit needs the source's own enable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : grpGen
      wire [7:0] mf = regFile_r[`MIC_IDX_MF0 + gi];
      assign grpHit[gi] = (groupEvent[2*gi+1] & mf[`MIC_BIT_MF_SRCB_E]) |
                          (groupEvent[2*gi] & mf[`MIC_BIT_MF_SRCA_E]);
    end
  endgenerate

  // per vector event, pending and acknowledge decode
  genvar vi;
  generate
    for (vi = 0; vi < NV; vi = vi + 1) begin : vecGen
      localparam integer RI = vecReg(vi);
      localparam integer BI = vecBit(vi);
      localparam integer GI = vecGrp(vi);
      localparam integer EI = vecEn(vi);
      if (GI >= 4) begin : grpVec
        assign vecSet[vi] = grpHit[GI-4];
      end else begin : dirVec
        assign vecSet[vi] = directEvent[dirMap(vi)];
      end
      // a flag needs its own enable and the global one before it requests
      assign pend[vi] = regFile_r[RI][BI] &
                        regFile_r[RI][EI] & globalEn;
      assign ackHot[vi] = ackOk && (irqVector_r == vi);
    end
  endgenerate

  mic_prio_pick #(
    .N(NV),
    .IW(4),
    .PRIO(PRIO)
  ) u_pick (
    .pend(pend),
    .found(pickFound),
    .idx(pickIdx)
  );

  // a stack that fills under a pending request refuses the ack
  assign ackOk = irqAck & irqReq_r & ~stackFull;

  // hardware set and clear masks over the whole register file
  always @* begin
    setAll = {(8*NR){1'b0}};
    clrAll = {(8*NR){1'b0}};
    ri = 0;
    bi = 0;
    for (v = 0; v < NV; v = v + 1) begin
      ri = vecReg(v);
      bi = vecBit(v);
      setAll[ri*8+bi] = vecSet[v];
      clrAll[ri*8+bi] = ackHot[v];
    end
    for (g = 0; g < 4; g = g + 1) begin
      setAll[(4+g)*8+`MIC_BIT_MF_SRCB_F] = groupEvent[2*g+1];
      setAll[(4+g)*8+`MIC_BIT_MF_SRCA_F] = groupEvent[2*g];
    end
    clrAll[`MIC_BIT_GLOBAL] = ackOk;
  end

  // next register values: write, then hardware clear, then set wins
  always @* begin
    regNxt = {(8*NR){1'b0}};
    tmpByte = 8'h00;
    for (r = 0; r < NR; r = r + 1) begin
      tmpByte = regFile_r[r];
      if (wrEn && (regIdx == r)) begin
        tmpByte = pwdata[7:0] & implMask(r);
      end
      tmpByte = (tmpByte & ~clrAll[r*8 +: 8]) | setAll[r*8 +: 8];
      regNxt[r*8 +: 8] = tmpByte & implMask(r);
    end
  end

  // every implemented bit comes up zero
  genvar rg;
  generate
    for (rg = 0; rg < NR; rg = rg + 1) begin : regGen
      always @(posedge clk_sys) begin
        if (!rstn) begin
          regFile_r[rg] <= `MIC_RST_VAL;
        end else begin
          regFile_r[rg] <= regNxt[rg*8 +: 8];
        end
      end
    end
  endgenerate

  // apb slave: pready in the second access cycle
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apbAcc & ~pready_r;
      if (apbAcc && !pready_r) begin
        pslverr_r <= ~mapped;
        // read data is captured with pready so it stands through the ack edge
        if (mapped && !pwrite) begin
          prdata_r <= {24'h000000, regFile_r[regIdx]};
        end else begin
          prdata_r <= 32'h00000000;
        end
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // vector address from base and stride
  assign vecProd = {8'h00, 8'h00, irqVector_r} * {12'h000, VEC_STEP};
  assign vecAddr = VEC_BASE + vecProd[11:0];

  // core handshake
  always @(posedge clk_sys) begin
    if (!rstn) begin
      irqReq_r <= 1'b0;
      irqVector_r <= 4'h0;
      vectorAddr_r <= 12'h000;
      pushStrobe_r <= 1'b0;
    end else begin
      // an ack in flight drops the request so one ack takes one vector
      irqReq_r <= pickFound & globalEn & ~stackFull & ~ackOk;
      // the vector is frozen on the ack edge so the clear hits the taken source
      if (!ackOk) begin
        irqVector_r <= pickIdx;
      end
      pushStrobe_r <= ackOk;
      if (ackOk) begin
        vectorAddr_r <= vecAddr;
      end
    end
  end

  // service depth follows push and pop
  // it saturates at both ends so a stray return or a deep nest cannot wrap
  assign popOk = retiPulse && (depth_r != {`MIC_DEPTH_W{1'b0}});
  assign pushOk = ackOk && (depth_r != DEPTH_MAX);

  always @* begin
    depthNxt = depth_r;
    if (pushOk && !popOk) begin
      depthNxt = depth_r + {{(`MIC_DEPTH_W-1){1'b0}}, 1'b1};
    end else if (popOk && !ackOk) begin
      depthNxt = depth_r - {{(`MIC_DEPTH_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      depth_r <= {`MIC_DEPTH_W{1'b0}};
      inService_r <= 1'b0;
      popStrobe_r <= 1'b0;
    end else begin
      depth_r <= depthNxt;
      inService_r <= (depthNxt != {`MIC_DEPTH_W{1'b0}});
      popStrobe_r <= retiPulse;
    end
  end

  // wake on any flag that an event sets from clear; a flag set by an apb write does not wake
  always @(posedge clk_sys) begin
    if (!rstn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= |(setAll & ~{regFile_r[7], regFile_r[6], regFile_r[5], regFile_r[4],
                             regFile_r[3], regFile_r[2], regFile_r[1],
                             regFile_r[0]});
    end
  end
endmodule

`default_nettype wire

// File: mic_irq_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic stackFull,
  input wire logic irqAck,
  input wire logic retiPulse,
  input wire logic [9:0] directEvent,
  input wire logic [7:0] groupEvent,
  input wire logic irqReq_r,
  input wire logic pushStrobe_r,
  input wire logic popStrobe_r,
  input wire logic inService_r,
  input wire logic wake_r,
  input wire logic [3:0] irqVector_r,
  input wire logic [11:0] vectorAddr_r,
  input wire logic [31:0] prdata_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_take;
    irqAck && irqReq_r && !stackFull;
  endsequence
  sequence s_full;
    stackFull && $past(stackFull) && $past(stackFull, 2);
  endsequence
  a_take_push: assert property (s_take |=> pushStrobe_r && inService_r)
    else $error("no push after ack");
  a_vector_addr: assert property (s_take |=>
    vectorAddr_r == 12'h004 + {6'h0, $past(irqVector_r), 2'h0}) else $error("bad vector");
  a_global_cleared: assert property (s_take |=> !irqReq_r [*3])
    else $error("request after ack");
  a_push_cause: assert property (pushStrobe_r |-> $past(irqAck && irqReq_r))
    else $error("push without ack");
  a_return_from_interrupt_pop: assert property (retiPulse |=> popStrobe_r)
    else $error("no pop");
  a_pop_cause: assert property (popStrobe_r |-> $past(retiPulse))
    else $error("pop without return");
  a_full_blocks: assert property (s_full |-> !irqReq_r)
    else $error("request with stack full");
  a_wake_cause: assert property (wake_r |-> $past(|directEvent || |groupEvent))
    else $error("wake without event");
  a_vector_range: assert property (irqReq_r |-> irqVector_r <= 4'hD)
    else $error("vector out of range");
  a_reset_clear: assert property ($rose(rstn) |->
    !irqReq_r && !inService_r && prdata_r == 32'h0) else $error("not clear after reset");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_chk mic_irq_ctrl_chk_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .stackFull(stackFull),
  .irqAck(irqAck),
  .retiPulse(retiPulse),
  .directEvent(directEvent),
  .groupEvent(groupEvent),
  .irqReq_r(irqReq_r),
  .pushStrobe_r(pushStrobe_r),
  .popStrobe_r(popStrobe_r),
  .inService_r(inService_r),
  .wake_r(wake_r),
  .irqVector_r(irqVector_r),
  .vectorAddr_r(vectorAddr_r),
  .prdata_r(prdata_r)
);
`default_nettype wire

// File: mic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mic_core_model #(parameter int DEPTH = 1) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic irqReq_r,
  input wire logic pushStrobe_r,
  input wire logic popStrobe_r,
  input wire logic retCmd,
  output logic irqAck,
  output logic retiPulse,
  output logic stackFull
);
  int depth;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqAck <= 1'b0;
      retiPulse <= 1'b0;
      depth <= 0;
    end else begin
      irqAck <= irqReq_r && !irqAck;
      retiPulse <= retCmd && !retiPulse;
      depth <= depth + int'(pushStrobe_r) - int'(popStrobe_r);
    end
  end
  assign stackFull = depth >= DEPTH;
endmodule
`default_nettype wire

// File: mic_irq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb;
  logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, retCmd = 0;
  logic [7:0] paddr = 8'h00, groupEvent = 8'h00;
  logic [9:0] directEvent = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata_r, q;
  logic pready_r, pslverr_r, stackFull, irqAck, retiPulse, irqReq_r, se;
  logic pushStrobe_r, popStrobe_r, inService_r, wake_r;
  logic [3:0] irqVector_r;
  logic [11:0] vectorAddr_r;
  logic [7:0] mask [8] = '{8'h7E, 8'hEE, 8'hFF, 8'hFF, 8'h33, 8'h33, 8'h33, 8'h33};
  logic [7:0] wval [8] = '{8'hFE, 8'hEE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  int err_total = 0, total_checks = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  mic_irq_ctrl mic_irq_ctrl_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata_r(prdata_r),
    .pready_r(pready_r),
    .pslverr_r(pslverr_r),
    .directEvent(directEvent),
    .groupEvent(groupEvent),
    .stackFull(stackFull),
    .irqAck(irqAck),
    .retiPulse(retiPulse),
    .irqReq_r(irqReq_r),
    .irqVector_r(irqVector_r),
    .vectorAddr_r(vectorAddr_r),
    .pushStrobe_r(pushStrobe_r),
    .popStrobe_r(popStrobe_r),
    .inService_r(inService_r),
    .wake_r(wake_r)
  );
  mic_core_model mic_core_model_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .irqReq_r(irqReq_r),
    .pushStrobe_r(pushStrobe_r),
    .popStrobe_r(popStrobe_r),
    .retCmd(retCmd),
    .irqAck(irqAck),
    .retiPulse(retiPulse),
    .stackFull(stackFull)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready_r !== 1'b1);
    q = prdata_r;
    se = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic ev(input logic [9:0] d, input logic [7:0] g);
    @(posedge clk_sys);
    directEvent <= d;
    groupEvent <= g;
    @(posedge clk_sys);
    directEvent <= 10'h000;
    groupEvent <= 8'h00;
  endtask
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 40 && s !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, s}, 32'h1);
  endtask
  task automatic ret;
    @(posedge clk_sys);
    retCmd <= 1'b1;
    @(posedge clk_sys);
    retCmd <= 1'b0;
    wait_hi(popStrobe_r);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk({q[30:0], se}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(8'(i * 4), {24'h0, wval[i]});
      rd(8'(i * 4), {24'h0, mask[i]});
      wr(8'(i * 4), 32'h0);
    end
    $display("register map test done");
    wr(8'h00, 32'h01);
    ev(10'h3FF, 8'h00);
    @(posedge clk_sys);
    chk({31'h0, wake_r}, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irqReq_r}, 32'h0);
    rd(8'h00, 32'h71);
    rd(8'h04, 32'hE0);
    rd(8'h08, 32'hD0);
    rd(8'h0C, 32'h80);
    for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'h0);
    $display("flag test done");
    wr(8'h00, 32'h04);
    ev(10'h002, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irqReq_r}, 32'h0);
    wr(8'h00, 32'h25);
    wait_hi(pushStrobe_r);
    chk({20'h0, vectorAddr_r}, 32'h008);
    rd(8'h00, 32'h04);
    ev(10'h002, 8'h00);
    rd(8'h00, 32'h24);
    ev(10'h002, 8'h00);
    @(posedge clk_sys);
    chk({31'h0, wake_r}, 32'h0);
    ret;
    chk({31'h0, inService_r}, 32'h0);
    $display("service test done");
    wr(8'h00, 32'h25);
    wait_hi(pushStrobe_r);
    ev(10'h002, 8'h00);
    wr(8'h00, 32'h25);
    repeat (6) @(posedge clk_sys);
    chk({31'h0, irqReq_r}, 32'h0);
    ret;
    wait_hi(pushStrobe_r);
    chk({20'h0, vectorAddr_r}, 32'h008);
    ret;
    $display("stack test done");
    wr(8'h00, 32'h0B);
    ev(10'h005, 8'h00);
    wait_hi(pushStrobe_r);
    chk({20'h0, vectorAddr_r}, 32'h004);
    rd(8'h00, 32'h1A);
    ret;
    wr(8'h00, 32'h1B);
    wait_hi(pushStrobe_r);
    chk({20'h0, vectorAddr_r}, 32'h00C);
    ret;
    $display("priority test done");
    wr(8'h10, 32'h03);
    wr(8'h0C, 32'h02);
    wr(8'h00, 32'h01);
    ev(10'h000, 8'h02);
    wait_hi(pushStrobe_r);
    chk({20'h0, vectorAddr_r}, 32'h034);
    chk({28'h0, irqVector_r}, 32'h0000000C);
    rd(8'h0C, 32'h02);
    rd(8'h10, 32'h23);
    wr(8'h10, 32'h03);
    ret;
    $display("group test done");
    final_report;
  end
endmodule
`default_nettype wire
